// >>> design/pkc_pkg.sv
// Constants, types and key tables for the configuration and key-detect block.
// Assumes a single 10 MHz clock; the host's port accesses arrive as
// one-cycle strobes that are already decoded.
package pkc_pkg;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CARD_NUMBER = 8'h06;
  localparam logic [7:0] IDX_IO_BASE_HIGH = 8'h60;
  localparam logic [7:0] IDX_IO_BASE_LOW = 8'h61;
  localparam logic [7:0] IDX_INTERRUPT_LINE_SELECT = 8'h70;
  localparam logic [7:0] IDX_INTERRUPT_KIND = 8'h71;
  localparam logic [7:0] IDX_DMA_SELECT_A = 8'h74;
  localparam logic [7:0] IDX_DMA_SELECT_B = 8'h75;
  localparam logic [7:0] IDX_SETUP_MIRROR_0 = 8'hf0;
  localparam logic [7:0] IDX_SETUP_MIRROR_1 = 8'hf1;
  localparam logic [7:0] IDX_SETUP_MIRROR_2 = 8'hf2;
  localparam logic [7:0] IDX_SETUP_MIRROR_3 = 8'hf3;
  localparam logic [7:0] IDX_SAVED_CARD_NUMBER_MIRROR = 8'hf5;
  localparam logic [7:0] IDX_VENDOR_COMMAND = 8'hf6;

  // ----------------------------------------------------------------
  // Fixed values, masks and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] INTERRUPT_KIND_VAL = 8'h02;
  localparam logic [7:0] DMA_NONE_VAL = 8'h04;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] IO_BASE_HIGH_MASK = 8'h03;
  localparam logic [7:0] IO_BASE_LOW_MASK = 8'he0;
  localparam logic [7:0] INTERRUPT_LINE_MASK = 8'h0f;
  localparam int VENDOR_CLEAR_BIT = 2;
  localparam int SR1_INTERRUPT_ENABLE_BIT = 7;
  localparam int SR2_BOOT_ROM_SELECT_BIT = 5;
  localparam int SR3_AUTOCONFIG_BIT = 7;
  localparam int SR3_RESERVED_BIT = 3;
  localparam int SR3_SLEEP_BIT = 2;
  localparam logic [4:0] KEY_LAST_POS = 5'h1f;
  localparam logic [4:0] KEY_FIRST_POS = 5'h00;
  localparam logic [4:0] KEY_SECOND_POS = 5'h01;

  // Standard and vendor key tables, first byte in the top bits
  localparam logic [255:0] STD_KEY = {128'h6ab5_daed_f6fb_7dbe_df6f_371b_0d86_c361,
    128'hb058_2c16_8b45_a2d1_e874_3a9d_cee7_7339};
  localparam logic [255:0] VND_KEY = {128'hda6d_361b_8d46_2391_48a4_d269_349a_4d26,
    128'h1389_44a2_5128_94ca_6532_190c_8643_a150};

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PKC_MODE_JUMPER = 2'b00,
    PKC_MODE_JUMPERLESS = 2'b01,
    PKC_MODE_AUTOCONFIG = 2'b11
  } pkc_mode_e;

  typedef enum logic [0:0] {
    PKC_WAIT_FOR_KEY = 1'b0,
    PKC_CONFIG = 1'b1
  } pkc_card_e;

  // Host port strobes, one cycle each
  typedef struct packed {
    logic addr_wr;
    logic data_wr;
    logic data_rd;
    logic [7:0] wdata;
  } pkc_isa_s;

  // Default source contents
  typedef struct packed {
    logic autoconfig_mode_bit;
    logic [7:0] setup_reg_0;
    logic [7:0] setup_reg_1;
    logic [7:0] setup_reg_2;
    logic [7:0] setup_reg_3;
  } pkc_dflt_s;

  // Setup register bank
  typedef struct packed {
    logic [7:0] setup_reg_0;
    logic [7:0] setup_reg_1;
    logic [7:0] setup_reg_2;
    logic [7:0] setup_reg_3;
    logic [7:0] saved_card_number;
  } pkc_setup_s;

  // Logical device configuration
  typedef struct packed {
    logic [7:0] io_base_high;
    logic [7:0] io_base_low;
    logic [7:0] interrupt_line_select;
  } pkc_cfg_s;

endpackage

// >>> design/pkc_config.sv
// Logical device configuration bank, mode selection and key detection.
// Assumes host port strobes are decoded and synchronous to clk, and that
// rst_b is the host reset drive, held low for at least one clock edge.
//
// Operation
// - I/O base high byte: bits 15..10 read zero, ignore writes.
// - I/O base low byte: bits 4..0 read zero, bits 7..5 writable.
// - Interrupt line select: low four bits, zero means none.
// - Interrupt kind reads fixed edge-triggered, active high value.
// - Both DMA selects read the no-channel code.
// - Vendor mirrors return current setup registers 0 to 3.
// - Saved card number mirror returns the saved copy.
// - Vendor command bit 2 clears card number, keeps copy, self-clears.
// - Mode from mode strap, autoconfig strap and stored autoconfig bit.
// - Setup 1 and 2 defaults from jumpers in jumper mode, else from stored image; setup 0 and 3 always from stored image.
// - Configuration writes accepted in all modes, reflected into setup.
// - Auto-load or reset restores setup and configuration defaults; the saved card number copy is kept.
// - Boot ROM size only from strap or stored source.
// - Vendor key always recognised; standard key only in autoconfig mode.
// - Vendor key enters Config in any mode.
// - Non-autoconfig defaults: interrupt enable one, boot ROM select zero.
// - Setup 3: bit 7 per mode, sleep and reserved bit 3 zero, rest from image.
// - Logic stays quiet after power up until a key is seen.
// - Full 32-write key on address port enables configuration ports.
// - Any key mismatch restarts the sequence, at the second position if the byte matches the first key byte.
// - Keys compared in order against fixed 32-byte tables.
// - Reset clears card number and enters Wait for Key.
// - Wait for Key ignores all configuration port accesses.
`timescale 1ns/100ps
`default_nettype none

module pkc_config (
  input wire logic clk, // 10 MHz clock
  input wire logic rst_b, // Host reset drive, low active
  input wire logic autoload, // Auto-load command pulse
  input wire logic mode_strap_pin, // High selects jumper mode
  input wire logic autoconfig_strap_pin, // High selects autoconfig unless mode strap pin high
  input wire pkc_pkg::pkc_dflt_s jumper_dflt, // Jumper pin image
  input wire pkc_pkg::pkc_dflt_s eeprom_dflt, // Stored image
  input wire pkc_pkg::pkc_isa_s isa, // Host port strobes
  output pkc_pkg::pkc_card_e card_state_q, // Card state
  output pkc_pkg::pkc_mode_e mode_q, // Configuration mode
  output logic [7:0] card_number_q, // Card select number
  output pkc_pkg::pkc_setup_s setup_q, // Setup bank
  output pkc_pkg::pkc_cfg_s cfg_q, // Configuration registers
  output logic [7:0] rd_data_q, // Read answer data
  output logic rd_valid_q // Read answer strobe
);
  import pkc_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] index_q;
  logic [4:0] std_pos_q;
  logic [4:0] vnd_pos_q;
  logic std_hit;
  logic vnd_hit;
  logic vnd_clear_q;
  logic load;
  logic cfg_wr;
  pkc_mode_e mode_d;
  pkc_dflt_s src;
  pkc_setup_s dflt_d;
  logic [7:0] rd_d;

  // Table lookup for one key position
  function automatic logic [7:0] key_byte(input logic [255:0] k, input logic [4:0] p);
    key_byte = k[(KEY_LAST_POS - p) * 8 +: 8];
  endfunction

  // ----------------------------------------------------------------
  // Mode and defaults
  // ----------------------------------------------------------------
  // Defaults reload on reset or auto-load
  // restore on reset
  assign load = !rst_b || autoload;
  assign cfg_wr = isa.data_wr && (card_state_q == PKC_CONFIG);

  // Mode decode from straps and stored bit
  always_comb begin
    if (mode_strap_pin) begin
      mode_d = PKC_MODE_JUMPER;
    end else if (autoconfig_strap_pin || eeprom_dflt.autoconfig_mode_bit) begin
      mode_d = PKC_MODE_AUTOCONFIG;
    end else begin
      mode_d = PKC_MODE_JUMPERLESS;
    end
  end

  // Default setup image per mode
  always_comb begin
    src = (mode_d == PKC_MODE_JUMPER) ? jumper_dflt : eeprom_dflt;
    dflt_d.setup_reg_0 = eeprom_dflt.setup_reg_0;
    dflt_d.setup_reg_1 = src.setup_reg_1;
    dflt_d.setup_reg_2 = src.setup_reg_2;
    dflt_d.setup_reg_3 = eeprom_dflt.setup_reg_3;
    dflt_d.saved_card_number = setup_q.saved_card_number;
    if (mode_d != PKC_MODE_AUTOCONFIG) begin
      dflt_d.setup_reg_1[SR1_INTERRUPT_ENABLE_BIT] = 1'b1;
      dflt_d.setup_reg_2[SR2_BOOT_ROM_SELECT_BIT] = 1'b0;
    end
    dflt_d.setup_reg_3[SR3_AUTOCONFIG_BIT] = (mode_d == PKC_MODE_AUTOCONFIG);
    dflt_d.setup_reg_3[SR3_SLEEP_BIT] = 1'b0;
    dflt_d.setup_reg_3[SR3_RESERVED_BIT] = 1'b0;
  end

  // Mode register
  always_ff @(posedge clk) begin
    if (load) begin
      mode_q <= mode_d;
    end
  end

  // ----------------------------------------------------------------
  // Key detection
  // ----------------------------------------------------------------
  // full series match
  assign std_hit = isa.addr_wr && (std_pos_q == KEY_LAST_POS) && (mode_q == PKC_MODE_AUTOCONFIG)
    && (isa.wdata == key_byte(STD_KEY, std_pos_q));
  assign vnd_hit = isa.addr_wr && (vnd_pos_q == KEY_LAST_POS)
    && (isa.wdata == key_byte(VND_KEY, vnd_pos_q));

  // Two parallel position counters fed by address-port writes
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      std_pos_q <= KEY_FIRST_POS;
      vnd_pos_q <= KEY_FIRST_POS;
    end else if (isa.addr_wr) begin
      if (isa.wdata == key_byte(STD_KEY, std_pos_q)) begin
        std_pos_q <= (std_pos_q == KEY_LAST_POS) ? KEY_FIRST_POS : std_pos_q + 5'h01;
      end else begin
        std_pos_q <= (isa.wdata == key_byte(STD_KEY, KEY_FIRST_POS)) ? KEY_SECOND_POS
          : KEY_FIRST_POS;
      end
      if (isa.wdata == key_byte(VND_KEY, vnd_pos_q)) begin
        vnd_pos_q <= (vnd_pos_q == KEY_LAST_POS) ? KEY_FIRST_POS : vnd_pos_q + 5'h01;
      end else begin
        vnd_pos_q <= (isa.wdata == key_byte(VND_KEY, KEY_FIRST_POS)) ? KEY_SECOND_POS
          : KEY_FIRST_POS;
      end
    end
  end

  // Card state: quiet until a key is seen
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      card_state_q <= PKC_WAIT_FOR_KEY;
    end else begin
      case (card_state_q)
        PKC_WAIT_FOR_KEY: begin
          if (std_hit || vnd_hit) begin
            card_state_q <= PKC_CONFIG;
          end
        end
        PKC_CONFIG: begin
          card_state_q <= PKC_CONFIG;
        end
        default: begin
          card_state_q <= PKC_WAIT_FOR_KEY;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Index and card number
  // ----------------------------------------------------------------
  // Index latched from address-port writes in Config
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      index_q <= ZERO_BYTE;
    end else if (isa.addr_wr && card_state_q == PKC_CONFIG) begin
      index_q <= isa.wdata;
    end
  end

  // Vendor clear command bit, self-clearing after one cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      vnd_clear_q <= 1'b0;
    end else begin
      vnd_clear_q <= cfg_wr && index_q == IDX_VENDOR_COMMAND && isa.wdata[VENDOR_CLEAR_BIT];
    end
  end

  // Card select number
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      card_number_q <= ZERO_BYTE;
    end else if (vnd_clear_q) begin
      card_number_q <= ZERO_BYTE;
    end else if (cfg_wr && index_q == IDX_CARD_NUMBER) begin
      card_number_q <= isa.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Configuration and setup storage
  // ----------------------------------------------------------------
  // Writes land in the configuration bank and reflect into setup 1; card number writes land in the saved copy
  always_ff @(posedge clk) begin
    if (load) begin
      setup_q <= dflt_d;
      cfg_q.io_base_high <= {6'h00, dflt_d.setup_reg_1[3:2]};
      cfg_q.io_base_low <= {dflt_d.setup_reg_1[1:0], 6'h00};
      cfg_q.interrupt_line_select <= {5'h00, dflt_d.setup_reg_1[6:4]};
    end else if (cfg_wr) begin
      case (index_q)
        IDX_IO_BASE_HIGH: begin
          cfg_q.io_base_high <= isa.wdata & IO_BASE_HIGH_MASK;
          setup_q.setup_reg_1[3:2] <= isa.wdata[1:0];
        end
        IDX_IO_BASE_LOW: begin
          cfg_q.io_base_low <= isa.wdata & IO_BASE_LOW_MASK;
          setup_q.setup_reg_1[1:0] <= isa.wdata[7:6];
        end
        IDX_INTERRUPT_LINE_SELECT: begin
          cfg_q.interrupt_line_select <= isa.wdata & INTERRUPT_LINE_MASK;
          setup_q.setup_reg_1[6:4] <= isa.wdata[2:0];
        end
        IDX_CARD_NUMBER: begin
          setup_q.saved_card_number <= isa.wdata;
        end
        default: begin
          setup_q <= setup_q;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read answer
  // ----------------------------------------------------------------
  // Read multiplexer
  always_comb begin
    case (index_q)
      IDX_CARD_NUMBER: rd_d = card_number_q;
      IDX_IO_BASE_HIGH: rd_d = cfg_q.io_base_high;
      IDX_IO_BASE_LOW: rd_d = cfg_q.io_base_low;
      IDX_INTERRUPT_LINE_SELECT: rd_d = cfg_q.interrupt_line_select;
      IDX_INTERRUPT_KIND: rd_d = INTERRUPT_KIND_VAL;
      IDX_DMA_SELECT_A: rd_d = DMA_NONE_VAL;
      IDX_DMA_SELECT_B: rd_d = DMA_NONE_VAL;
      IDX_SETUP_MIRROR_0: rd_d = setup_q.setup_reg_0;
      IDX_SETUP_MIRROR_1: rd_d = setup_q.setup_reg_1;
      IDX_SETUP_MIRROR_2: rd_d = setup_q.setup_reg_2;
      IDX_SETUP_MIRROR_3: rd_d = setup_q.setup_reg_3;
      IDX_SAVED_CARD_NUMBER_MIRROR: rd_d = setup_q.saved_card_number;
      default: rd_d = ZERO_BYTE;
    endcase
  end

  // Answer one cycle after a read strobe, none while waiting for key
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rd_valid_q <= 1'b0;
      rd_data_q <= ZERO_BYTE;
    end else begin
      rd_valid_q <= isa.data_rd && card_state_q == PKC_CONFIG;
      rd_data_q <= (isa.data_rd && card_state_q == PKC_CONFIG) ? rd_d : ZERO_BYTE;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_IOB_HIGH_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
    cfg_q.io_base_high[7:2] == 6'h00) else $error("I/O base high upper bits set");
  AST_IOB_LOW_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
    cfg_q.io_base_low[4:0] == 5'h00) else $error("I/O base low bits set");
  AST_LINE_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
    (cfg_wr && !autoload && index_q == IDX_INTERRUPT_LINE_SELECT) |=>
    cfg_q.interrupt_line_select == {4'h0, $past(isa.wdata[3:0])})
    else $error("Interrupt line select not stored");
  AST_KIND_READ: assert property (@(posedge clk) disable iff (!rst_b)
    (isa.data_rd && card_state_q == PKC_CONFIG && index_q == IDX_INTERRUPT_KIND) |=>
    (rd_valid_q && rd_data_q == INTERRUPT_KIND_VAL)) else $error("Interrupt kind wrong");
  AST_DMA_READ: assert property (@(posedge clk) disable iff (!rst_b)
    (isa.data_rd && card_state_q == PKC_CONFIG
    && (index_q == IDX_DMA_SELECT_A || index_q == IDX_DMA_SELECT_B)) |=>
    rd_data_q == DMA_NONE_VAL) else $error("DMA select wrong");
  AST_MIRROR_READ: assert property (@(posedge clk) disable iff (!rst_b)
    (isa.data_rd && card_state_q == PKC_CONFIG && index_q == IDX_SETUP_MIRROR_3) |=>
    rd_data_q == $past(setup_q.setup_reg_3)) else $error("Setup mirror wrong");
  AST_VENDOR_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
    (cfg_wr && index_q == IDX_VENDOR_COMMAND && isa.wdata[VENDOR_CLEAR_BIT] && !autoload) |=>
    ##1 (card_number_q == ZERO_BYTE && !vnd_clear_q
    && setup_q.saved_card_number == $past(setup_q.saved_card_number, 2)))
    else $error("Vendor clear failed");
  AST_WAIT_QUIET: assert property (@(posedge clk) disable iff (!rst_b)
    (card_state_q == PKC_WAIT_FOR_KEY) |=> !rd_valid_q) else $error("Answer while waiting");
  AST_RESET_STATE: assert property (@(posedge clk)
    !rst_b |=> (card_state_q == PKC_WAIT_FOR_KEY && card_number_q == ZERO_BYTE
    && setup_q.setup_reg_3[SR3_SLEEP_BIT] == 1'b0)) else $error("Reset state wrong");
  AST_STD_KEY_MODE: assert property (@(posedge clk) disable iff (!rst_b)
    ($rose(card_state_q) && mode_q != PKC_MODE_AUTOCONFIG) |->
    $past(vnd_hit)) else $error("Standard key accepted outside autoconfig");
  AST_SAVED_READ: assert property (@(posedge clk) disable iff (!rst_b)
    (isa.data_rd && card_state_q == PKC_CONFIG && index_q == IDX_SAVED_CARD_NUMBER_MIRROR)
    |=> rd_data_q == $past(setup_q.saved_card_number)) else $error("Saved copy mirror wrong");

  // Mode decode from straps at each load
  AST_MODE_JUMPER: assert property (@(posedge clk)
    (load && mode_strap_pin) |=> mode_q == PKC_MODE_JUMPER)
    else $error("Jumper mode not taken");
  AST_MODE_AUTO: assert property (@(posedge clk)
    (load && !mode_strap_pin && (autoconfig_strap_pin || eeprom_dflt.autoconfig_mode_bit))
    |=> mode_q == PKC_MODE_AUTOCONFIG) else $error("Autoconfig mode not taken");
  AST_MODE_PLAIN: assert property (@(posedge clk)
    (load && !mode_strap_pin && !autoconfig_strap_pin && !eeprom_dflt.autoconfig_mode_bit)
    |=> mode_q == PKC_MODE_JUMPERLESS) else $error("Jumperless mode not taken");

  // Forced default bits after every load
  AST_FORCED_BITS: assert property (@(posedge clk) load |=>
    (mode_q == PKC_MODE_AUTOCONFIG || (setup_q.setup_reg_1[SR1_INTERRUPT_ENABLE_BIT]
    && !setup_q.setup_reg_2[SR2_BOOT_ROM_SELECT_BIT]))) else $error("Forced setup bits wrong");
  AST_SETUP3_BITS: assert property (@(posedge clk) load |=>
    (setup_q.setup_reg_3[SR3_AUTOCONFIG_BIT] == (mode_q == PKC_MODE_AUTOCONFIG)
    && !setup_q.setup_reg_3[SR3_SLEEP_BIT])) else $error("Setup 3 forced bits wrong");

  // Key position bookkeeping, quiet state, write protection and covers
  AST_KEY_RESTART: assert property (@(posedge clk) disable iff (!rst_b)
    (isa.addr_wr && isa.wdata != key_byte(STD_KEY, std_pos_q)
    && isa.wdata != key_byte(STD_KEY, KEY_FIRST_POS)) |=> std_pos_q == KEY_FIRST_POS)
    else $error("Key position not restarted");
  AST_ADDR_ONLY: assert property (@(posedge clk) disable iff (!rst_b)
    !isa.addr_wr |=> ($stable(std_pos_q) && $stable(vnd_pos_q)))
    else $error("Key position moved without address write");
  AST_QUIET_WAIT: assert property (@(posedge clk) disable iff (!rst_b)
    (card_state_q == PKC_WAIT_FOR_KEY && !isa.addr_wr) |=> card_state_q == PKC_WAIT_FOR_KEY)
    else $error("Left Wait for Key without a key");
  AST_NO_SIZE_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
    (cfg_wr && !autoload) |=> $stable(setup_q.setup_reg_2))
    else $error("Boot ROM size written");
  AST_READONLY_KEEP: assert property (@(posedge clk) disable iff (!rst_b)
    (cfg_wr && !autoload && index_q >= IDX_SETUP_MIRROR_0) |=> ($stable(cfg_q)
    && $stable(setup_q.setup_reg_1) && $stable(setup_q.setup_reg_3)))
    else $error("Read-only write changed state");

  COV_STD_KEY: cover property (@(posedge clk) disable iff (!rst_b) std_hit);
  COV_VND_KEY: cover property (@(posedge clk) disable iff (!rst_b)
    vnd_hit && mode_q == PKC_MODE_JUMPER);
  COV_VND_CLEAR: cover property (@(posedge clk) disable iff (!rst_b) vnd_clear_q);
  COV_CFG_WRITE: cover property (@(posedge clk) disable iff (!rst_b)
    cfg_wr && index_q == IDX_IO_BASE_LOW);
  COV_PLAIN_KEY: cover property (@(posedge clk) disable iff (!rst_b)
    vnd_hit && mode_q == PKC_MODE_JUMPERLESS);

endmodule // pkc_config

`default_nettype wire

// >>> bench/pkc_host_model.sv
// Host model: configuration software driving the device's port strobes.
// Assumes a read answer stands in the cycle after the read strobe.
`timescale 1ns/100ps
`default_nettype none

module pkc_host_model (
  input wire logic clk, // Device clock
  output var pkc_pkg::pkc_isa_s isa, // Port strobes to the device
  input wire logic rd_valid, // Read answer strobe
  input wire logic [7:0] rd_data // Read answer data
);
  import pkc_pkg::*;

  // ----------------------------------------------------------------
  // Key tables, first byte in the top bits
  // ----------------------------------------------------------------
  localparam logic [255:0] HOST_STD_KEY = {128'h6ab5_daed_f6fb_7dbe_df6f_371b_0d86_c361,
    128'hb058_2c16_8b45_a2d1_e874_3a9d_cee7_7339};
  localparam logic [255:0] HOST_VND_KEY = {128'hda6d_361b_8d46_2391_48a4_d269_349a_4d26,
    128'h1389_44a2_5128_94ca_6532_190c_8643_a150};

  initial isa = '0;

  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // One strobe cycle, then release with toggled data lines
  task automatic strobe(input logic a, input logic w, input logic r, input logic [7:0] dv);
    @(posedge clk);
    isa <= '{addr_wr: a, data_wr: w, data_rd: r, wdata: dv};
    @(posedge clk);
    isa <= '{addr_wr: 1'b0, data_wr: 1'b0, data_rd: 1'b0, wdata: ~dv};
  endtask

  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] val);
    strobe(1'b1, 1'b0, 1'b0, idx);
    strobe(1'b0, 1'b1, 1'b0, val);
  endtask

  // Answer is sampled mid-cycle, while it stands
  task automatic rd_reg(input logic [7:0] idx, output logic ok, output logic [7:0] dv);
    strobe(1'b1, 1'b0, 1'b0, idx);
    strobe(1'b0, 1'b0, 1'b1, 8'h00);
    @(negedge clk);
    ok = rd_valid;
    dv = rd_data;
  endtask

  // byte at bad_pos inverted to break it
  task automatic send_key(input logic vnd, input int bad_pos);
    logic [7:0] b;
    for (int i = 0; i < 32; i++) begin
      b = vnd ? HOST_VND_KEY[255 - 8 * i -: 8] : HOST_STD_KEY[255 - 8 * i -: 8];
      if (i == bad_pos) b = ~b;
      strobe(1'b1, 1'b0, 1'b0, b);
    end
  endtask
endmodule // pkc_host_model

`default_nettype wire

// >>> bench/tb_top.sv
// Testbench for the configuration bank and key detector.
// Assumes the host model drives port cycles; strap pins set during reset.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import pkc_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic autoload = 1'b0;
  logic mode_strap_pin = 1'b1;
  logic autoconfig_strap_pin = 1'b0;
  pkc_dflt_s jumper_dflt = '{1'b0, 8'h00, 8'h4a, 8'hf3, 8'h00};
  pkc_dflt_s eeprom_dflt = '{1'b0, 8'h5c, 8'h35, 8'hff, 8'h7f};
  pkc_isa_s isa;
  pkc_card_e card_state_q;
  pkc_mode_e mode_q;
  logic [7:0] card_number_q;
  pkc_setup_s setup_q;
  pkc_cfg_s cfg_q;
  logic [7:0] rd_data_q;
  logic rd_valid_q;
  int err_count = 0;
  int compares = 0;
  int cycles = 0;
  logic v;
  logic [7:0] d;
  logic auto_m;
  logic [1:0] exp_mode;
  logic [2:0] mtab [4] = '{3'b010, 3'b001, 3'b000, 3'b100};

  always #50 clk = ~clk;

  pkc_config u_dut (
    .clk(clk), .rst_b(rst_b), .autoload(autoload), .mode_strap_pin(mode_strap_pin),
    .autoconfig_strap_pin(autoconfig_strap_pin), .jumper_dflt(jumper_dflt),
    .eeprom_dflt(eeprom_dflt), .isa(isa), .card_state_q(card_state_q), .mode_q(mode_q),
    .card_number_q(card_number_q), .setup_q(setup_q), .cfg_q(cfg_q),
    .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q)
  );

  pkc_host_model u_host (
    .clk(clk), .isa(isa), .rd_valid(rd_valid_q), .rd_data(rd_data_q)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic ok;
    logic [7:0] got;
    u_host.rd_reg(idx, ok, got);
    chk8({7'h00, ok}, 8'h01);
    chk8(got, exp);
  endtask

  task automatic wr_rd(input logic [7:0] idx, input logic [7:0] w, input logic [7:0] exp);
    u_host.wr_reg(idx, w);
    rd_chk(idx, exp);
  endtask

  // Reset held ten cycles with the straps applied
  task automatic do_reset(input logic jp, input logic ac, input logic eb);
    @(posedge clk);
    rst_b <= 1'b0;
    mode_strap_pin <= jp;
    autoconfig_strap_pin <= ac;
    eeprom_dflt.autoconfig_mode_bit <= eb;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, cycles, 0);
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    // Each mode: defaults, quiet state, key acceptance
    for (int m = 0; m < 4; m++) begin
      do_reset(mtab[m][2], mtab[m][1], mtab[m][0]);
      auto_m = !mtab[m][2] && (mtab[m][1] || mtab[m][0]);
      exp_mode = mtab[m][2] ? PKC_MODE_JUMPER
        : (auto_m ? PKC_MODE_AUTOCONFIG : PKC_MODE_JUMPERLESS);
      chk8({6'h00, mode_q}, {6'h00, exp_mode});
      chk8({7'h00, card_state_q}, 8'h00);
      chk8(card_number_q, 8'h00);
      chk8(setup_q.setup_reg_0, 8'h5c);
      chk8(setup_q.setup_reg_1, auto_m ? 8'h35 : (mtab[m][2] ? 8'hca : 8'hb5));
      chk8(setup_q.setup_reg_2, auto_m ? 8'hff : (mtab[m][2] ? 8'hd3 : 8'hdf));
      chk8(setup_q.setup_reg_3, auto_m ? 8'hf3 : 8'h73);
      u_host.rd_reg(IDX_INTERRUPT_KIND, v, d);
      chk8({7'h00, v}, 8'h00);
      u_host.send_key(1'b0, 32);
      @(negedge clk);
      chk8({7'h00, card_state_q}, {7'h00, auto_m});
      do_reset(mtab[m][2], mtab[m][1], mtab[m][0]);
      u_host.send_key(1'b1, 10);
      @(negedge clk);
      chk8({7'h00, card_state_q}, 8'h00);
      u_host.send_key(1'b1, 32);
      @(negedge clk);
      chk8({7'h00, card_state_q}, 8'h01);
      $display("Mode test %0d done", m);
    end
    // Fixed and read-only places, jumper mode in Config
    rd_chk(IDX_INTERRUPT_KIND, 8'h02);
    rd_chk(IDX_DMA_SELECT_A, 8'h04);
    rd_chk(IDX_DMA_SELECT_B, 8'h04);
    u_host.wr_reg(IDX_INTERRUPT_KIND, 8'hff);
    u_host.wr_reg(IDX_DMA_SELECT_B, 8'hff);
    u_host.wr_reg(IDX_SETUP_MIRROR_2, 8'h00);
    rd_chk(IDX_INTERRUPT_KIND, 8'h02);
    rd_chk(IDX_DMA_SELECT_B, 8'h04);
    rd_chk(IDX_SETUP_MIRROR_2, 8'hd3);
    rd_chk(8'hf4, 8'h00);
    rd_chk(IDX_SETUP_MIRROR_0, 8'h5c);
    rd_chk(IDX_SETUP_MIRROR_3, 8'h73);
    $display("Fixed register test done");
    // Writable fields, masks and reflection into setup
    wr_rd(IDX_IO_BASE_HIGH, 8'hff, 8'h03);
    wr_rd(IDX_IO_BASE_LOW, 8'hff, 8'he0);
    wr_rd(IDX_INTERRUPT_LINE_SELECT, 8'hf0, 8'h00);
    wr_rd(IDX_INTERRUPT_LINE_SELECT, 8'h0f, 8'h0f);
    u_host.rd_reg(IDX_SETUP_MIRROR_1, v, d);
    chk8(d & 8'h7f, 8'h7f);
    wr_rd(IDX_IO_BASE_HIGH, 8'h02, 8'h02);
    wr_rd(IDX_IO_BASE_LOW, 8'h40, 8'h40);
    wr_rd(IDX_INTERRUPT_LINE_SELECT, 8'h05, 8'h05);
    u_host.rd_reg(IDX_SETUP_MIRROR_1, v, d);
    chk8(d & 8'h7f, 8'h59);
    chk8(setup_q.setup_reg_2, 8'hd3);
    $display("Configuration write test done");
    // Card number, saved copy and vendor clear
    u_host.wr_reg(IDX_CARD_NUMBER, 8'h05);
    u_host.wr_reg(IDX_VENDOR_COMMAND, 8'hfb);
    repeat (3) @(negedge clk);
    chk8(card_number_q, 8'h05);
    rd_chk(IDX_SAVED_CARD_NUMBER_MIRROR, 8'h05);
    u_host.wr_reg(IDX_VENDOR_COMMAND, 8'h04);
    repeat (3) @(negedge clk);
    chk8(card_number_q, 8'h00);
    rd_chk(IDX_SAVED_CARD_NUMBER_MIRROR, 8'h05);
    $display("Card number test done");
    // Auto-load and reset drop software changes
    @(posedge clk);
    autoload <= 1'b1;
    @(posedge clk);
    autoload <= 1'b0;
    repeat (2) @(negedge clk);
    chk8(setup_q.setup_reg_1, 8'hca);
    chk8(setup_q.setup_reg_2, 8'hd3);
    chk8({5'h00, cfg_q.interrupt_line_select[2:0]}, 8'h04);
    chk8({6'h00, cfg_q.io_base_high[1:0]}, 8'h02);
    chk8({7'h00, card_state_q}, 8'h01);
    u_host.wr_reg(IDX_INTERRUPT_LINE_SELECT, 8'h07);
    do_reset(1'b1, 1'b0, 1'b0);
    chk8(setup_q.setup_reg_1, 8'hca);
    chk8({7'h00, card_state_q}, 8'h00);
    $display("Restore test done");
    wrap_up();
  end
endmodule // tb_top

`default_nettype wire
